// file: core/scs_clock_select.sv
// Purpose: core clock source selection, high-frequency post-divider, trim and suspend control
// Assumes: oscillator outputs arrive as pin levels far slower than clk; registers on the sfr bus
// Notes: the core clock leaves as a one-cycle enable pulse, one per core clock period
//
// Functional notes
// - selector 000 gives divided high-frequency clock, 011 gives it undivided
// - selector 010 gives divided low-frequency clock, 101 low-power, others reserved
// - external oscillator drives core clock only with selector 001
// - external oscillator stays available to timers and counter array at all times
// - source may change any time; software picks only enabled, settled sources
// - internal high and low frequency sources usable right after enabling write
// - low-power oscillator runs while it is the chosen core clock and until the handover away from it completes
// - hardware raises the crystal settled flag once the crystal is stable
// - after reset the divided high-frequency source drives, selector reads zero
// - post-divider divides the high-frequency clock by 2, 4, 8 or 16
// - post-divider ratio is sixteen after reset
// - writing suspend stops the oscillator and gates its core clock until wake
// - wake on port 0 match, port 1 match, enabled comparator low, timer 3 overflow
// - any wake event resumes oscillator and core, interrupt or not
// - seven-bit trim sets period: zeros fastest, ones slowest
// - trim loads factory value on the first clock after reset release, top bit reads zero, ignores writes
// - upper five selector register bits read zero and ignore writes
// - divide select field sits in bits 1 to 0 of the control register
`timescale 1ns/1ps
`include "scs_regs.svh"
module scs_clock_select (
  input wire logic clk,
  input wire logic arst_n,
  input wire scs_pkg::scs_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic [6:0] trim_factory,
  input wire logic hf_osc_clk,
  input wire logic lf_osc_div_clk,
  input wire logic lp_osc_clk,
  input wire logic ext_osc_clk,
  input wire logic xtal_settled_pin,
  input wire scs_pkg::scs_wake_t wake_pins,
  output logic core_clock_out,
  output logic core_halted,
  output logic hf_osc_enable,
  output logic hf_osc_ready,
  output logic [6:0] hf_osc_trim_out,
  output logic lp_osc_enable,
  output logic ext_periph_tick,
  output logic crystal_settled_flag
);

  // synchroniser lane numbers
  localparam int N_SYNC = 10;
  localparam int L_HF = 0;
  localparam int L_LF = 1;
  localparam int L_LP = 2;
  localparam int L_EXT = 3;
  localparam int L_XTAL = 4;
  localparam int L_P0 = 5;
  localparam int L_P1 = 6;
  localparam int L_CMPEN = 7;
  localparam int L_CMPOUT = 8;
  localparam int L_T3 = 9;

  // decodes the divide select code into the last divider count
  function automatic logic [3:0] div_last(input logic [1:0] code);
    logic [3:0] last;
    last = `SCS_HF_DIV16_LAST;
    case (code)
      `SCS_HF_DIV16_CODE: last = `SCS_HF_DIV16_LAST;
      `SCS_HF_DIV8_CODE: last = `SCS_HF_DIV8_LAST;
      `SCS_HF_DIV4_CODE: last = `SCS_HF_DIV4_LAST;
      `SCS_HF_DIV2_CODE: last = `SCS_HF_DIV2_LAST;
      default: last = `SCS_HF_DIV16_LAST;
    endcase
    return last;
  endfunction

  // true for selector codes that name a real source
  function automatic logic src_valid(input logic [2:0] code);
    logic ok;
    ok = 1'h0;
    case (code)
      scs_pkg::SCS_SRC_HF_DIV: ok = 1'h1;
      scs_pkg::SCS_SRC_EXT: ok = 1'h1;
      scs_pkg::SCS_SRC_LF: ok = 1'h1;
      scs_pkg::SCS_SRC_HF_RAW: ok = 1'h1;
      scs_pkg::SCS_SRC_LP: ok = 1'h1;
      default: ok = 1'h0;
    endcase
    return ok;
  endfunction

  // true when the code names one of the high-frequency sources
  function automatic logic src_is_hf(input logic [2:0] code);
    return (code == scs_pkg::SCS_SRC_HF_DIV) || (code == scs_pkg::SCS_SRC_HF_RAW);
  endfunction

  logic [N_SYNC-1:0] pin_in;
  logic [N_SYNC-1:0] sync1_ff;
  logic [N_SYNC-1:0] sync2_ff;
  logic [N_SYNC-1:0] sync3_ff;
  logic [N_SYNC-1:0] rise;

  logic [2:0] core_clock_out_source_sel_ff;
  logic hf_en_ff;
  logic suspend_ff;
  logic [1:0] hf_divide_sel_ff;
  logic [6:0] hf_osc_trim_ff;
  logic trim_loaded_ff;
  logic [3:0] div_cnt_ff;
  logic core_tick_ff;
  logic ext_tick_ff;
  logic xtal_ff;
  logic [7:0] rdata_ff;

  logic nxt_suspend;
  logic [6:0] nxt_trim;
  logic [3:0] nxt_div_cnt;

  logic wr_sel;
  logic wr_ctrl;
  logic wr_trim;
  logic hf_run;
  logic hf_tick;
  logic hf_div_tick;
  logic [3:0] cnt_last;
  logic wake;
  logic [7:0] src_tick;
  logic sw_tick;
  logic sw_busy;
  scs_pkg::scs_src_t cur_src;
  scs_pkg::scs_src_t req_src;
  logic req_ok;
  logic [7:0] hf_osc_control_reg;
  logic [7:0] rd_val;

  // every pin level from another domain is gathered into one vector
  assign pin_in = {
    wake_pins.timer3_ovf,
    wake_pins.cmp0_out,
    wake_pins.cmp0_enabled,
    wake_pins.port1_match,
    wake_pins.port0_match,
    xtal_settled_pin,
    ext_osc_clk,
    lp_osc_clk,
    lf_osc_div_clk,
    hf_osc_clk
  };

  // two-flop synchronisers plus a third flop for edge detection on the second
  genvar gi;
  generate
    for (gi = 0; gi < N_SYNC; gi++) begin : g_sync
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          sync1_ff[gi] <= 1'h0;
          sync2_ff[gi] <= 1'h0;
          sync3_ff[gi] <= 1'h0;
        end else begin
          sync1_ff[gi] <= pin_in[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          sync3_ff[gi] <= sync2_ff[gi];
        end
      end
      assign rise[gi] = sync2_ff[gi] & ~sync3_ff[gi];
    end
  endgenerate

  // register write decode
  assign wr_sel = sfr_req.we && (sfr_req.addr == `SCS_SRC_SEL_ADDR);
  assign wr_ctrl = sfr_req.we && (sfr_req.addr == `SCS_HF_CTRL_ADDR);
  assign wr_trim = sfr_req.we && (sfr_req.addr == `SCS_HF_TRIM_ADDR);

  // wake events; a level wake holds the oscillator out of suspend while it stands
  assign wake = sync2_ff[L_P0] | sync2_ff[L_P1]
    | (sync2_ff[L_CMPEN] & ~sync2_ff[L_CMPOUT])
    | rise[L_T3];

  // a suspend write in the same cycle as a wake wins, since the wake predates it
  assign nxt_suspend = wr_ctrl ? sfr_req.wdata[`SCS_HF_SUSP_BIT]
    : (wake ? 1'h0 : suspend_ff);

  // only the low seven trim bits exist; factory value lands once after reset
  assign nxt_trim = wr_trim ? sfr_req.wdata[`SCS_HF_TRIM_MSB:0]
    : (trim_loaded_ff ? hf_osc_trim_ff : trim_factory);

  // oscillator runs when enabled and not suspended; ticks ignored otherwise
  assign hf_run = hf_en_ff & ~suspend_ff;
  assign hf_tick = rise[L_HF] & hf_run;

  // post-divider; a count past a newly shortened ratio wraps at once
  assign cnt_last = div_last(hf_divide_sel_ff);
  assign hf_div_tick = hf_tick && (div_cnt_ff >= cnt_last);
  assign nxt_div_cnt = !hf_tick ? div_cnt_ff
    : (hf_div_tick ? 4'h0 : div_cnt_ff + 4'h1);

  // tick per source, indexed by selector code; reserved codes carry nothing
  assign src_tick[scs_pkg::SCS_SRC_HF_DIV] = hf_div_tick;
  assign src_tick[scs_pkg::SCS_SRC_EXT] = rise[L_EXT];
  assign src_tick[scs_pkg::SCS_SRC_LF] = rise[L_LF];
  assign src_tick[scs_pkg::SCS_SRC_HF_RAW] = hf_tick;
  assign src_tick[4] = 1'h0;
  assign src_tick[scs_pkg::SCS_SRC_LP] = rise[L_LP];
  assign src_tick[6] = 1'h0;
  assign src_tick[7] = 1'h0;

  // a reserved code leaves the running source in place
  assign req_ok = src_valid(core_clock_out_source_sel_ff);
  assign req_src = scs_pkg::scs_src_t'(core_clock_out_source_sel_ff);

  // handover between sources happens on period boundaries only
  scs_clk_switch u_switch (
    .clk(clk),
    .arst_n(arst_n),
    .src_tick(src_tick),
    .req_sel(req_src),
    .req_valid(req_ok),
    .tick_out(sw_tick),
    .cur_sel(cur_src),
    .busy(sw_busy)
  );

  // core is halted while suspended on a high-frequency source
  assign core_halted = suspend_ff && src_is_hf(cur_src);

  // low-power oscillator kept on until the handover away from it completes
  assign lp_osc_enable = (core_clock_out_source_sel_ff == scs_pkg::SCS_SRC_LP)
    || (cur_src == scs_pkg::SCS_SRC_LP) || (sw_busy && req_src == scs_pkg::SCS_SRC_LP);

  assign hf_osc_enable = hf_run;
  assign hf_osc_ready = hf_run;
  assign hf_osc_trim_out = hf_osc_trim_ff;
  assign core_clock_out = core_tick_ff;
  assign ext_periph_tick = ext_tick_ff;
  assign crystal_settled_flag = xtal_ff;
  assign sfr_rdata = rdata_ff;

  // control register image; bits 4 to 2 read zero
  assign hf_osc_control_reg = {
    hf_en_ff,
    hf_run,
    suspend_ff,
    3'h0,
    hf_divide_sel_ff
  };

  // read select; unmapped addresses read zero
  assign rd_val = (sfr_req.addr == `SCS_SRC_SEL_ADDR) ? {5'h00, core_clock_out_source_sel_ff}
    : (sfr_req.addr == `SCS_HF_CTRL_ADDR) ? hf_osc_control_reg
    : (sfr_req.addr == `SCS_HF_TRIM_ADDR) ? {1'h0, hf_osc_trim_ff}
    : 8'h00;

  // selector register; reset returns to the divided high-frequency source
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      core_clock_out_source_sel_ff <= `SCS_SRC_SEL_RST;
    end else if (wr_sel) begin
      core_clock_out_source_sel_ff <= sfr_req.wdata[`SCS_SRC_SEL_MSB:0];
    end
  end

  // control register fields
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hf_en_ff <= `SCS_HF_EN_RST;
      hf_divide_sel_ff <= `SCS_HF_DIV_RST;
    end else if (wr_ctrl) begin
      hf_en_ff <= sfr_req.wdata[`SCS_HF_EN_BIT];
      hf_divide_sel_ff <= sfr_req.wdata[`SCS_HF_DIV_MSB:0];
    end
  end

  // suspend state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      suspend_ff <= `SCS_HF_SUSP_RST;
    end else begin
      suspend_ff <= nxt_suspend;
    end
  end

  // trim is a strap caught after reset release, not under the reset itself
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hf_osc_trim_ff <= `SCS_HF_TRIM_RST;
      trim_loaded_ff <= 1'h0;
    end else begin
      hf_osc_trim_ff <= nxt_trim;
      trim_loaded_ff <= 1'h1;
    end
  end

  // post-divider counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_ff <= 4'h0;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
    end
  end

  // registered outputs; external tick goes to peripherals whatever drives the core
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      core_tick_ff <= 1'h0;
      ext_tick_ff <= 1'h0;
      xtal_ff <= 1'h0;
    end else begin
      core_tick_ff <= sw_tick & ~core_halted;
      ext_tick_ff <= rise[L_EXT];
      xtal_ff <= sync2_ff[L_XTAL];
    end
  end

  // read data register, updated on each read strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 8'h00;
    end else if (sfr_req.re) begin
      rdata_ff <= rd_val;
    end
  end

endmodule

// file: include/scs_regs.svh
// Purpose: register offsets, field positions and reset values of the clock select block
// Assumes: byte-wide special function register bus, registers at their printed addresses
// Notes: divide select codes map 00 to the slowest ratio so that reset gives divide by sixteen
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH

// register addresses on the special function register bus
`define SCS_SRC_SEL_ADDR 8'hA9
`define SCS_HF_CTRL_ADDR 8'hB2
`define SCS_HF_TRIM_ADDR 8'hB3

// source select register fields
`define SCS_SRC_SEL_MSB 2
`define SCS_SRC_SEL_RST 3'h0

// high-frequency control register fields
`define SCS_HF_EN_BIT 7
`define SCS_HF_RDY_BIT 6
`define SCS_HF_SUSP_BIT 5
`define SCS_HF_DIV_MSB 1
`define SCS_HF_EN_RST 1'h1
`define SCS_HF_SUSP_RST 1'h0
`define SCS_HF_DIV_RST 2'h0

// divide select codes and the last count of each ratio
`define SCS_HF_DIV16_CODE 2'h0
`define SCS_HF_DIV8_CODE 2'h1
`define SCS_HF_DIV4_CODE 2'h2
`define SCS_HF_DIV2_CODE 2'h3
`define SCS_HF_DIV16_LAST 4'hF
`define SCS_HF_DIV8_LAST 4'h7
`define SCS_HF_DIV4_LAST 4'h3
`define SCS_HF_DIV2_LAST 4'h1

// trim register fields
`define SCS_HF_TRIM_MSB 6
`define SCS_HF_TRIM_RST 7'h00

`endif

// file: include/scs_pkg.sv
// Purpose: shared types of the clock select block
// Assumes: used with scs_regs.svh for all numeric constants
// Notes: source codes follow the selector encoding, reserved codes have no member
package scs_pkg;

  // core clock sources, encoded as the selector field
  typedef enum logic [2:0] {
    SCS_SRC_HF_DIV = 3'h0,
    SCS_SRC_EXT = 3'h1,
    SCS_SRC_LF = 3'h2,
    SCS_SRC_HF_RAW = 3'h3,
    SCS_SRC_LP = 3'h5
  } scs_src_t;

  // states of the glitch-free source handover
  typedef enum logic [1:0] {
    SCS_SW_RUN = 2'h0,
    SCS_SW_DRAIN = 2'h1,
    SCS_SW_ALIGN = 2'h2
  } scs_sw_state_t;

  // one register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } scs_sfr_req_t;

  // wake sources, all pin levels from other domains
  typedef struct packed {
    logic port0_match;
    logic port1_match;
    logic cmp0_enabled;
    logic cmp0_out;
    logic timer3_ovf;
  } scs_wake_t;

endpackage

// file: core/scs_clk_switch.sv
// Purpose: glitch-free handover of the core clock tick between sources
// Assumes: src_tick holds one-cycle tick pulses, one per source period
// Notes: a dead old source stalls the handover; software only picks live sources
`timescale 1ns/1ps
module scs_clk_switch (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] src_tick,
  input wire scs_pkg::scs_src_t req_sel,
  input wire logic req_valid,
  output logic tick_out,
  output scs_pkg::scs_src_t cur_sel,
  output logic busy
);

  scs_pkg::scs_sw_state_t state_ff;
  scs_pkg::scs_sw_state_t nxt_state;
  scs_pkg::scs_src_t cur_ff;
  scs_pkg::scs_src_t nxt_cur;
  scs_pkg::scs_src_t tgt_ff;
  scs_pkg::scs_src_t nxt_tgt;
  logic cur_tick;

  assign cur_tick = src_tick[cur_ff];
  assign cur_sel = cur_ff;
  assign busy = (state_ff != scs_pkg::SCS_SW_RUN);

  // old source ends its period, new source's first tick is swallowed to start a whole one
  always_comb begin
    nxt_state = state_ff;
    nxt_cur = cur_ff;
    nxt_tgt = tgt_ff;
    tick_out = 1'h0;
    case (state_ff)
      scs_pkg::SCS_SW_RUN: begin
        tick_out = cur_tick;
        if (req_valid && req_sel != cur_ff) begin
          nxt_tgt = req_sel;
          nxt_state = scs_pkg::SCS_SW_DRAIN;
        end
      end
      scs_pkg::SCS_SW_DRAIN: begin
        tick_out = cur_tick;
        if (req_valid) begin
          nxt_tgt = req_sel;
        end
        if (cur_tick) begin
          nxt_cur = req_valid ? req_sel : tgt_ff;
          nxt_state = scs_pkg::SCS_SW_ALIGN;
        end
      end
      scs_pkg::SCS_SW_ALIGN: begin
        if (cur_tick) begin
          nxt_state = scs_pkg::SCS_SW_RUN;
        end
      end
      default: begin
        nxt_state = scs_pkg::SCS_SW_RUN;
      end
    endcase
  end

  // handover state, reset onto the divided high-frequency source
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= scs_pkg::SCS_SW_RUN;
      cur_ff <= scs_pkg::SCS_SRC_HF_DIV;
      tgt_ff <= scs_pkg::SCS_SRC_HF_DIV;
    end else begin
      state_ff <= nxt_state;
      cur_ff <= nxt_cur;
      tgt_ff <= nxt_tgt;
    end
  end

endmodule

// file: dv/scs_clock_select_asserts.sv
// Purpose: temporal checks on the clock select ports
// Assumes: oscillator levels far slower than clk
// Notes: bound into every clock select instance
`timescale 1ns/1ps
module scs_clock_select_asserts (
  input wire logic clk,
  input wire logic arst_n,
  input wire scs_pkg::scs_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic [6:0] trim_factory,
  input wire logic ext_osc_clk,
  input wire logic xtal_settled_pin,
  input wire scs_pkg::scs_wake_t wake_pins,
  input wire logic core_clock_out,
  input wire logic core_halted,
  input wire logic hf_osc_enable,
  input wire logic hf_osc_ready,
  input wire logic [6:0] hf_osc_trim_out,
  input wire logic lp_osc_enable,
  input wire logic ext_periph_tick
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // bus decode and level wake sources
  wire wr_sel = sfr_req.we && sfr_req.addr == 8'hA9;
  wire wr_ctl = sfr_req.we && sfr_req.addr == 8'hB2;
  wire lvl_wake = wake_pins.port0_match || wake_pins.port1_match || (wake_pins.cmp0_enabled && !wake_pins.cmp0_out);

  a_halt_gates_clk: assert property (core_halted && $past(core_halted) |-> !core_clock_out)
    else $error("core pulse while halted");
  a_suspend_stops: assert property (wr_ctl && sfr_req.wdata[5] |=> !hf_osc_enable && !hf_osc_ready)
    else $error("suspend left oscillator on");
  a_ready_no_wait: assert property (wr_ctl && sfr_req.wdata[7] && !sfr_req.wdata[5] |=> hf_osc_ready)
    else $error("oscillator not ready after enable");
  a_wake_resumes: assert property (core_halted && (lvl_wake || $rose(wake_pins.timer3_ovf)) |-> ##[1:6] !core_halted)
    else $error("wake did not resume core");
  a_pulse_one_cycle: assert property (core_clock_out |=> !core_clock_out)
    else $error("core pulse too long");
  a_ext_tick_live: assert property ($rose(ext_osc_clk) && $past(arst_n, 3) |-> ##[1:4] ext_periph_tick)
    else $error("external tick missing");
  a_lp_on_select: assert property (wr_sel && sfr_req.wdata[2:0] == 3'h5 |-> ##[1:2] lp_osc_enable)
    else $error("low-power oscillator off");
  a_select_upper_zero: assert property (sfr_req.re && sfr_req.addr == 8'hA9 |=> sfr_rdata[7:3] == 5'h00)
    else $error("selector upper bits set");
  a_trim_top_zero: assert property (sfr_req.re && sfr_req.addr == 8'hB3 |=> !sfr_rdata[7])
    else $error("trim top bit set");
  a_trim_factory: assert property ($rose(arst_n) && !sfr_req.we |=> hf_osc_trim_out == $past(trim_factory))
    else $error("factory trim not loaded");
endmodule

bind scs_clock_select scs_clock_select_asserts i_chk (.clk, .arst_n, .sfr_req, .sfr_rdata, .trim_factory, .ext_osc_clk,
  .xtal_settled_pin, .wake_pins, .core_clock_out, .core_halted, .hf_osc_enable, .hf_osc_ready, .hf_osc_trim_out,
  .lp_osc_enable, .ext_periph_tick);

// file: dv/scs_osc_model.sv
// Purpose: behavioural oscillators feeding the clock select block
// Assumes: periods are whole clk periods, phases off the rising clk edges
// Notes: a stopped oscillator sits low, as the real cells do
`timescale 1ns/1ps
module scs_osc_model #(
  parameter int HF_P = 120,
  parameter int LF_P = 400,
  parameter int LP_P = 560,
  parameter int EXT_P = 280
) (
  input wire logic hf_osc_enable,
  input wire logic lp_osc_enable,
  output logic hf_osc_clk,
  output logic lf_osc_div_clk,
  output logic lp_osc_clk,
  output logic ext_osc_clk
);
  logic hf_run = 1'b0;
  logic lp_run = 1'b0;
  // free-running phases; hf and lf edges fall on falling clk edges, lp and ext are offset off every clk edge
  initial begin
    lf_osc_div_clk = 1'b0;
    ext_osc_clk = 1'b0;
    fork
      forever #(HF_P / 2) hf_run = ~hf_run;
      forever #(LF_P / 2) lf_osc_div_clk = ~lf_osc_div_clk;
      #4 forever #(LP_P / 2) lp_run = ~lp_run;
      #6 forever #(EXT_P / 2) ext_osc_clk = ~ext_osc_clk;
    join
  end
  // no settle time: running from the enabling write on
  assign hf_osc_clk = hf_run & hf_osc_enable;
  assign lp_osc_clk = lp_run & lp_osc_enable;
endmodule

// file: dv/system_clock_select_test.sv
// Purpose: self-checking bench of the clock select block
// Assumes: oscillator model periods are whole clk periods
// Notes: core clock periods measured between enable pulses
`timescale 1ns/1ps
module system_clock_select_test;
  localparam int HF_P = 120;
  localparam int LF_P = 400;
  localparam int LP_P = 560;
  localparam int EXT_P = 280;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  scs_pkg::scs_sfr_req_t sfr_req = '0;
  scs_pkg::scs_wake_t wake_pins = 5'h06;
  logic [6:0] trim_factory;
  logic xtal_settled_pin = 1'b0;
  logic [7:0] sfr_rdata;
  logic [6:0] hf_osc_trim_out;
  logic hf_osc_clk, lf_osc_div_clk, lp_osc_clk, ext_osc_clk;
  logic core_clock_out, core_halted, hf_osc_enable, lp_osc_enable, crystal_settled_flag;
  logic hf_osc_ready, ext_periph_tick;
  logic [2:0] src_tab [4] = '{3'h1, 3'h2, 3'h3, 3'h5};
  logic [7:0] d;
  logic [2:0] s;
  int err_count = 0;
  int n_checks = 0;
  int seed = 24637;
  int n_ext = 0;
  int e0;
  time t0;

  initial begin
    forever #10 clk = ~clk;
  end
  scs_osc_model #(.HF_P(HF_P), .LF_P(LF_P), .LP_P(LP_P), .EXT_P(EXT_P)) i_osc (.hf_osc_enable, .lp_osc_enable,
    .hf_osc_clk, .lf_osc_div_clk, .lp_osc_clk, .ext_osc_clk);
  scs_clock_select i_dut (.clk, .arst_n, .sfr_req, .sfr_rdata, .trim_factory, .hf_osc_clk, .lf_osc_div_clk,
    .lp_osc_clk, .ext_osc_clk, .xtal_settled_pin, .wake_pins, .core_clock_out, .core_halted, .hf_osc_enable,
    .hf_osc_ready, .hf_osc_trim_out, .lp_osc_enable, .ext_periph_tick, .crystal_settled_flag);

  // external ticks counted off the launching edge, whatever source drives the core
  always @(negedge clk) begin
    if (ext_periph_tick === 1'b1) begin
      n_ext++;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bus write, then read compared with expectation
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    sfr_req <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
    @(posedge clk);
    sfr_req.we <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfr_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk);
    sfr_req.re <= 1'b0;
    @(negedge clk);
    chk(sfr_rdata, e);
  endtask
  // bounded wait for the next core pulse
  task automatic pulse();
    int n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (core_clock_out !== 1'b1 && n < 3000);
    chk(16'(n < 3000), 16'h0001);
  endtask
  // skip the handover, then time one full period
  task automatic meas(input int e);
    repeat (3) pulse();
    t0 = $time;
    pulse();
    chk(16'($time - t0), 16'(e));
  endtask
  function automatic int exp_per(input logic [2:0] sel, input logic [1:0] dv);
    case (sel)
      3'h0: return HF_P * (16 >> dv);
      3'h1: return EXT_P;
      3'h2: return LF_P;
      3'h5: return LP_P;
      default: return HF_P;
    endcase
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // whole run needs just over 1 ms, mostly the crystal wait; 1.8 ms means a hang
  initial begin
    #1800000;
    err_count++;
    results();
  end

  initial begin
    trim_factory = 7'($random(seed));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    rchk(8'hA9, 8'h00);
    rchk(8'hB2, 8'hC0);
    rchk(8'hB3, {1'b0, trim_factory});
    rchk(8'hB4, 8'h00);
    wr(8'hA9, 8'hFB);
    rchk(8'hA9, 8'h03);
    repeat (3) begin
      d = 8'($random(seed));
      wr(8'hB3, d);
      rchk(8'hB3, {1'b0, d[6:0]});
      chk(hf_osc_trim_out, d[6:0]);
    end
    $display("test registers done");
    // every divide code, then every other source
    for (int i = 0; i < 8; i++) begin
      s = (i < 4) ? 3'h0 : src_tab[i - 4];
      wr(8'hB2, 8'h80 | 8'(i[1:0]));
      // flash read timing lives outside this block and is taken as set before a fast source
      wr(8'hA9, {5'h00, s});
      meas(exp_per(s, i[1:0]));
      chk(lp_osc_enable, s == 3'h5);
    end
    wr(8'hA9, 8'h06);
    meas(LP_P);
    $display("test sources done");
    wr(8'hA9, 8'h00);
    meas(2 * HF_P);
    chk(lp_osc_enable, 1'b0);
    // comparator enabled but high must not wake
    for (int k = 0; k < 4; k++) begin
      wr(8'hB2, 8'hA3);
      repeat (20 + $unsigned($random(seed)) % 32) @(negedge clk);
      chk({hf_osc_enable, hf_osc_ready, core_halted}, 3'b001);
      @(posedge clk);
      case (k)
        0: wake_pins.port0_match <= 1'b1;
        1: wake_pins.port1_match <= 1'b1;
        2: wake_pins.cmp0_out <= 1'b0;
        default: wake_pins.timer3_ovf <= 1'b1;
      endcase
      repeat (6) @(negedge clk);
      chk({hf_osc_enable, hf_osc_ready, core_halted}, 3'b110);
      @(posedge clk);
      wake_pins <= 5'h06;
      meas(2 * HF_P);
    end
    rchk(8'hB2, 8'hC3);
    $display("test suspend done");
    // flag stays low until the crystal settles; software waits 1 ms before trusting it
    chk(crystal_settled_flag, 1'b0);
    e0 = n_ext;
    repeat (100) @(posedge clk);
    xtal_settled_pin <= 1'b1;
    repeat (49900) @(posedge clk);
    chk(16'((n_ext - e0 >= 1000000 / EXT_P) && (n_ext - e0 <= 1000000 / EXT_P + 1)), 16'h0001);
    @(negedge clk);
    chk(crystal_settled_flag, 1'b1);
    $display("test crystal done");
    results();
  end
endmodule
